/* File: stap_scan_test_access_port.sv */
`timescale 1ns/1ps
module stap_scan_test_access_port
	import stap_pkg::*;
(
	input  wire logic                  mclk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  tck_in,
	input  wire logic                  tms_in,
	input  wire logic                  tdi_in,
	input  wire logic                  trst_in,
	output logic                       tdo_out,
	output logic                       tdo_oe_n_out,
	input  wire logic                  emulator_event_pin_a_in,
	output logic                       emulator_event_pin_a_out,
	output logic                       emulator_event_pin_a_oe_n_out,
	input  wire logic                  emulator_event_pin_b_in,
	output logic                       emulator_event_pin_b_out,
	output logic                       emulator_event_pin_b_oe_n_out,
	output logic                       crystal_drive_output_oe_n_out,
	output logic                       scan_control_out,
	output logic                       emu_event_a_out,
	output logic                       emu_event_b_out,
	output stap_word_type              word_out,
	output logic                       word_valid_out,
	input  wire logic                  word_ready_in
);

	// next state of the access port controller from mode select
	function automatic stap_state_type tap_next(input stap_state_type s, input logic m);
		unique case (s)
			ST_RESET:  tap_next = m ? ST_RESET  : ST_IDLE;
			ST_IDLE:   tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SHF_DR;
			ST_SHF_DR: tap_next = m ? ST_EX1_DR : ST_SHF_DR;
			ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SHF_DR;
			ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: tap_next = m ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SHF_IR;
			ST_SHF_IR: tap_next = m ? ST_EX1_IR : ST_SHF_IR;
			ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SHF_IR;
			ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
		endcase
	endfunction

	stap_state_type        state_q;
	logic [IR_W-1:0]       ir_sr_q;
	logic [IR_W-1:0]       ir_q;
	logic [ID_W-1:0]       id_sr_q;
	logic [EMU_W-1:0]      emu_sr_q;
	logic [DAT_W-1:0]      dat_sr_q;
	logic                  byp_q;
	stap_emu_ctrl_type     emu_ctrl_q;
	stap_word_type         xfer_word_q;
	logic                  req_q;
	logic [2:0]            ack_sync_q;
	logic                  ack_q;
	logic                  busy;
	logic                  tdo_d;
	logic                  tdo_q;
	logic                  tdo_oe_n_q;

	// controller state walks on each test clock rise; test reset low holds it in reset
	always_ff @(posedge tck_in or negedge trst_in)
	begin
		if (!trst_in)
			state_q <= ST_RESET;
		else
			state_q <= tap_next(state_q, tms_in);
	end

	// instruction register capture, shift and update
	always_ff @(posedge tck_in or negedge trst_in)
	begin
		if (!trst_in)
		begin
			ir_sr_q <= IR_RESET;
			ir_q    <= IR_RESET;
		end
		else
		begin
			if (state_q == ST_CAP_IR)
				ir_sr_q <= IR_CAPTURE;
			else if (state_q == ST_SHF_IR)
				ir_sr_q <= {tdi_in, ir_sr_q[IR_W-1:1]};
			if (state_q == ST_RESET)
				ir_q <= IR_RESET;
			else if (state_q == ST_UPD_IR)
				ir_q <= ir_sr_q;
		end
	end

	// data registers: all capture together; the instruction picks which one shifts
	always_ff @(posedge tck_in or negedge trst_in)
	begin
		if (!trst_in)
		begin
			id_sr_q  <= IDCODE_VAL;
			emu_sr_q <= EMU_CTRL_RESET;
			dat_sr_q <= '0;
			byp_q    <= 1'b0;
		end
		else if (state_q == ST_CAP_DR)
		begin
			id_sr_q  <= IDCODE_VAL;
			emu_sr_q <= emu_ctrl_q;
			dat_sr_q <= {busy, xfer_word_q.data};
			byp_q    <= 1'b0;
		end
		else if (state_q == ST_SHF_DR)
		begin
			unique case (ir_q)
				OP_IDCODE:   id_sr_q  <= {tdi_in, id_sr_q[ID_W-1:1]};
				OP_EMU_CTRL: emu_sr_q <= {tdi_in, emu_sr_q[EMU_W-1:1]};
				OP_DATA:     dat_sr_q <= {tdi_in, dat_sr_q[DAT_W-1:1]};
				default:     byp_q    <= tdi_in;
			endcase
		end
	end

	// event pin control register, loaded at update when selected
	always_ff @(posedge tck_in or negedge trst_in)
	begin
		if (!trst_in)
			emu_ctrl_q <= EMU_CTRL_RESET;
		else if (state_q == ST_UPD_DR && ir_q == OP_EMU_CTRL)
			emu_ctrl_q <= emu_sr_q;
	end

	// ack toggle returns from the core clock through three flops, counted once the last two agree
	always_ff @(posedge tck_in or negedge trst_in)
	begin
		if (!trst_in)
			ack_sync_q <= 3'h0;
		else
			ack_sync_q <= {ack_sync_q[1:0], ack_q};
	end

	assign busy = !(ack_sync_q[1] == ack_sync_q[2] && ack_sync_q[2] == req_q);

	// word update raises a toggle request; an update while busy is dropped
	always_ff @(posedge tck_in or negedge trst_in)
	begin
		if (!trst_in)
		begin
			req_q       <= 1'b0;
			xfer_word_q <= WORD_RESET;
		end
		else if (state_q == ST_UPD_DR && ir_q == OP_DATA && !busy)
		begin
			req_q       <= !req_q;
			xfer_word_q <= dat_sr_q[WORD_W-1:0];
		end
	end

	// selected register's low bit feeds the output
	always_comb
	begin
		tdo_d = byp_q;
		if (state_q == ST_SHF_IR)
			tdo_d = ir_sr_q[0];
		else
			unique case (ir_q)
				OP_IDCODE:   tdo_d = id_sr_q[0];
				OP_EMU_CTRL: tdo_d = emu_sr_q[0];
				OP_DATA:     tdo_d = dat_sr_q[0];
				default:     tdo_d = byp_q;
			endcase
	end

	// output data and its enable change on the falling test clock edge
	always_ff @(negedge tck_in or negedge trst_in)
	begin
		if (!trst_in)
		begin
			tdo_q      <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end
		else
		begin
			tdo_q      <= tdo_d;
			tdo_oe_n_q <= !(state_q == ST_SHF_IR || state_q == ST_SHF_DR);
		end
	end

	assign tdo_out      = tdo_q;
	assign tdo_oe_n_out = tdo_oe_n_q;

	// event pins drive only under scan control and when scan set them as outputs
	assign emulator_event_pin_a_out      = emu_ctrl_q.out_a;
	assign emulator_event_pin_a_oe_n_out = !emu_ctrl_q.dir_a;
	assign emulator_event_pin_b_out      = emu_ctrl_q.out_b;
	assign emulator_event_pin_b_oe_n_out = !emu_ctrl_q.dir_b;

	// core clock side
	logic [SYNC_N-1:0]     pin_sync_q [3];
	logic [2:0]            pin_lvl_q;
	logic [2:0]            pin_raw;
	logic [2:0]            req_sync_q;
	logic                  xtal_oe_n_q;
	stap_word_type         buf_mem_q [BUF_DEPTH];
	logic                  wr_ptr_q;
	logic                  rd_ptr_q;
	logic [1:0]            count_q;
	logic                  push;
	logic                  pop;
	logic                  full;

	assign pin_raw = {emulator_event_pin_b_in, emulator_event_pin_a_in, trst_in};

	// three flop pin filters; level follows once second and third stage agree
	for (genvar g = 0; g < 3; g++)
	begin : g_pin
		always_ff @(posedge mclk_in or negedge rstn_in)
		begin
			if (!rstn_in)
			begin
				pin_sync_q[g] <= '0;
				pin_lvl_q[g]  <= PIN_RESET[g];
			end
			else
			begin
				pin_sync_q[g] <= {pin_sync_q[g][SYNC_N-2:0], pin_raw[g]};
				if (pin_sync_q[g][1] == pin_sync_q[g][2])
					pin_lvl_q[g] <= pin_sync_q[g][2];
			end
		end
	end

	// scan control and pin events; with test reset high, low output-disable floats the crystal drive
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			xtal_oe_n_q <= 1'b0;
		else
			xtal_oe_n_q <= pin_lvl_q[PIN_TRST] && !pin_lvl_q[PIN_EMU_B];
	end

	assign scan_control_out              = pin_lvl_q[PIN_TRST];
	assign emu_event_a_out               = pin_lvl_q[PIN_TRST] && pin_lvl_q[PIN_EMU_A];
	assign emu_event_b_out               = pin_lvl_q[PIN_TRST] && pin_lvl_q[PIN_EMU_B];
	assign crystal_drive_output_oe_n_out = xtal_oe_n_q;

	// request toggle crossing; only the second and third flops are compared
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			req_sync_q <= 3'h0;
		else
			req_sync_q <= {req_sync_q[1:0], req_q};
	end

	assign full = count_q == 2'(BUF_DEPTH);
	assign push = pin_lvl_q[PIN_TRST] && req_sync_q[1] == req_sync_q[2]
		&& req_sync_q[2] != ack_q && !full;
	assign pop  = word_valid_out && word_ready_in;

	// two entry buffer; ack is held back while full so the scan side stays busy
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ack_q    <= 1'b0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_mem_q[i] <= WORD_RESET;
		end
		else
		begin
			if (push)
			begin
				buf_mem_q[wr_ptr_q] <= xfer_word_q;
				wr_ptr_q            <= !wr_ptr_q;
				ack_q               <= req_sync_q[2];
			end
			else if (!pin_lvl_q[PIN_TRST] && !full)
				ack_q <= req_sync_q[2]; // a request cut by test reset is forgotten
			if (pop)
				rd_ptr_q <= !rd_ptr_q;
			count_q <= count_q + 2'(push) - 2'(pop);
		end
	end

	assign word_valid_out = count_q != 2'h0;
	assign word_out       = buf_mem_q[rd_ptr_q];

	// five high mode select samples reach reset from anywhere
	a_tap_reset_reach: assert property (@(posedge tck_in) disable iff (!trst_in)
		tms_in [*5] |=> state_q == ST_RESET)
		else $error("controller missed reset after five high mode select samples");

	a_tms_idle_step: assert property (@(posedge tck_in) disable iff (!trst_in)
		(state_q == ST_RESET && !tms_in) |=> state_q == ST_IDLE)
		else $error("low mode select in reset did not step to idle");

	a_ir_shift_in: assert property (@(posedge tck_in) disable iff (!trst_in)
		state_q == ST_SHF_IR |=> ir_sr_q[IR_W-1] == $past(tdi_in))
		else $error("instruction shift did not take the data input");

	a_bypass_tdo: assert property (@(posedge tck_in) disable iff (!trst_in)
		(state_q == ST_SHF_DR && ir_q == OP_BYPASS) |-> (tdo_q == byp_q && !tdo_oe_n_q))
		else $error("bypass bit not presented on data output");

	a_emu_pin_dir: assert property (@(posedge tck_in) disable iff (!trst_in)
		(state_q == ST_UPD_DR && ir_q == OP_EMU_CTRL && emu_sr_q[1])
		|=> !emulator_event_pin_a_oe_n_out)
		else $error("event pin a not driven after scan set it as output");

	a_xtal_float: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(pin_lvl_q[PIN_TRST] && !pin_lvl_q[PIN_EMU_B]) |=> crystal_drive_output_oe_n_out)
		else $error("crystal drive not floated while output disable low");

	a_scan_release: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(pin_sync_q[PIN_TRST][1] == pin_sync_q[PIN_TRST][2] && !pin_sync_q[PIN_TRST][2])
		|=> !scan_control_out ##0 !emu_event_a_out)
		else $error("scan control not released with test reset low");

	a_buf_no_over: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		full |=> count_q <= 2'(BUF_DEPTH) && (ack_q == $past(ack_q) || $past(pop)) == 1'b1)
		else $error("buffer overfilled or acked while full");

endmodule

/* File: stap_pkg.sv */
// What this block does
// - capture test data in into the selected instruction or data register on test clock rise.
// - shift the selected register out on test data out at each test clock fall.
// - sample mode select into the access port state controller on test clock rise.
// - with test reset high, the scan system takes control of the device.
// - with test reset low or open, run functionally and ignore scan signals.
// - with test reset high, event pin a is an emulator interrupt, direction set by scan.
// - with test reset high, event pin b is an emulator interrupt, direction set by scan.
// - with test reset high, crystal drive output goes high impedance while the output-disable pin is low.
package stap_pkg;

	// access port controller states
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} stap_state_type;

	// instruction register layout and opcodes
	localparam int          IR_W        = 4;
	localparam logic [3:0]  IR_CAPTURE  = 4'h1;
	localparam logic [3:0]  OP_IDCODE   = 4'h1;
	localparam logic [3:0]  OP_EMU_CTRL = 4'h2;
	localparam logic [3:0]  OP_DATA     = 4'h3;
	localparam logic [3:0]  OP_BYPASS   = 4'hf;
	localparam logic [3:0]  IR_RESET    = OP_IDCODE;

	// identity word, value arbitrary, bit 0 set as scan convention demands
	localparam logic [31:0] IDCODE_VAL  = 32'h0000_1001;

	// data register widths
	localparam int          ID_W        = 32;
	localparam int          EMU_W       = 4;
	localparam int          WORD_W      = 16;
	localparam int          DAT_W       = WORD_W + 1;
	localparam int          BUSY_BIT    = WORD_W;

	// event pin control fields, carried through the control register
	typedef struct packed {
		logic dir_b;
		logic out_b;
		logic dir_a;
		logic out_a;
	} stap_emu_ctrl_type;
	localparam stap_emu_ctrl_type EMU_CTRL_RESET = 4'h0;

	// word handed from the scan side to the core side
	typedef struct packed {
		logic [WORD_W-1:0] data;
	} stap_word_type;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

	// core side buffer and pin synchroniser geometry
	localparam int          BUF_DEPTH   = 2;
	localparam int          SYNC_N      = 3;
	localparam int          PIN_TRST    = 0;
	localparam int          PIN_EMU_A   = 1;
	localparam int          PIN_EMU_B   = 2;
	localparam logic [2:0]  PIN_RESET   = 3'h0;

endpackage

/* File: stap_jtag_host.sv */
`timescale 1ns/1ps
module stap_jtag_host (
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	input  wire logic tdo_in
);
	// link clock stands low outside frames, released data line sits at its pull-up
	initial
	begin
		tck_out = 1'h0;
		tms_out = 1'h1;
		tdi_out = 1'h1;
	end

	// one link period: change after the fall, sample the answer on the rise
	task automatic step(input logic m, input logic di, output logic o);
		tms_out = m;
		tdi_out = di;
		#40 tck_out = 1'h1;
		o = tdo_in;
		#40 tck_out = 1'h0;
	endtask

	// five highs reach reset from any state, one low parks in idle
	task automatic to_idle();
		logic o;
		repeat (5) step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
	endtask

	// idle, select, capture, shift n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		repeat (3) step(1'h0, 1'h1, o);
		step(1'h1, 1'h1, o);
		if (ir)
			step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
		step(1'h0, 1'h1, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
	endtask
endmodule

/* File: stap_scan_test_access_port_tb.sv */
`timescale 1ns/1ps
module stap_scan_test_access_port_tb
	import stap_pkg::*;
;
	logic          mclk, rstn, trst, rdy, a_drv, b_drv;
	wire           tck, tms, tdi;
	logic          tdo, tdo_oe_n, a_out, a_oe_n, b_out, b_oe_n;
	logic          xoe_n, sc, ev_a, ev_b, vld;
	stap_word_type word;
	int            failures, samples_checked;
	logic [31:0]   d, r;
	logic [15:0]   q[$];
	// pin level from both parties, the testbench drive when the device releases it
	wire           pin_a = !a_oe_n ? a_out : a_drv;
	wire           pin_b = !b_oe_n ? b_out : b_drv;
	// released data output falls to its pull-down
	wire           tdo_line = !tdo_oe_n ? tdo : 1'h0;

	stap_jtag_host u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_line));

	stap_scan_test_access_port u_dut (
		.mclk_in(mclk), .rstn_in(rstn), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
		.trst_in(trst), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n),
		.emulator_event_pin_a_in(pin_a), .emulator_event_pin_a_out(a_out),
		.emulator_event_pin_a_oe_n_out(a_oe_n), .emulator_event_pin_b_in(pin_b),
		.emulator_event_pin_b_out(b_out), .emulator_event_pin_b_oe_n_out(b_oe_n),
		.crystal_drive_output_oe_n_out(xoe_n), .scan_control_out(sc),
		.emu_event_a_out(ev_a), .emu_event_b_out(ev_b), .word_out(word),
		.word_valid_out(vld), .word_ready_in(rdy));

	initial
	begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic tally_and_finish();
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// bypass shows a captured zero, then the input delayed by one
	function automatic logic [31:0] byp(input logic [31:0] v);
		return {24'h0, v[6:0], 1'h0};
	endfunction

	// let the pin filters follow
	task automatic settle();
		repeat (10) @(negedge mclk);
	endtask

	// watchdog
	initial
	begin
		#400000;
		failures++;
		tally_and_finish();
	end

	initial
	begin
		rstn = 1'h0;
		trst = 1'h0;
		rdy = 1'h0;
		a_drv = 1'h1;
		b_drv = 1'h1;
		failures = 0;
		samples_checked = 0;
		void'($urandom(41224));
		repeat (12) @(negedge mclk);
		rstn = 1'h1;
		settle();
		chk(sc, 1'h0, "scan control without test reset");
		trst = 1'h1;
		settle();
		chk(sc, 1'h1, "scan control with test reset");
		u_host.to_idle();
		u_host.scan(1'h0, ID_W, $urandom, d);
		chk(d, IDCODE_VAL, "identity shift");
		u_host.scan(1'h1, IR_W, OP_BYPASS, d);
		chk(d[3:0], IR_CAPTURE, "instruction capture");
		r = $urandom;
		u_host.scan(1'h0, 8, r, d);
		chk(d, byp(r), "bypass delay");
		// every direction pair of the event pins, random levels both ways
		u_host.scan(1'h1, IR_W, OP_EMU_CTRL, d);
		for (int i = 0; i < 4; i++)
		begin
			r = $urandom;
			r[1] = i[0];
			r[3] = i[1];
			u_host.scan(1'h0, EMU_W, r, d);
			@(negedge mclk);
			a_drv = 1'($urandom);
			b_drv = 1'($urandom);
			settle();
			chk(pin_a, r[1] ? r[0] : a_drv, "pin a level");
			chk(ev_a, r[1] ? r[0] : a_drv, "pin a event");
			chk(pin_b, r[3] ? r[2] : b_drv, "pin b level");
			chk(ev_b, r[3] ? r[2] : b_drv, "pin b event");
			chk(xoe_n, r[3] ? !r[2] : !b_drv, "crystal float");
		end
		// words under a stalled core: two fit, third waits, fourth refused
		u_host.scan(1'h1, IR_W, OP_DATA, d);
		for (int i = 0; i < 4; i++)
		begin
			r = $urandom;
			u_host.scan(1'h0, DAT_W, r, d);
			chk(d[BUSY_BIT], i > 2, "busy flag");
			if (i < 3)
				q.push_back(r[15:0]);
			settle();
		end
		chk(word.data, q[0], "head held under stall");
		@(negedge mclk);
		rdy = 1'h1;
		for (int n = 0; n < 40; n++)
		begin
			if (vld === 1'h1 && q.size() > 0)
				chk(word.data, q.pop_front(), "stream word");
			@(negedge mclk);
		end
		chk(q.size(), 0, "words lost");
		chk(vld, 1'h0, "refused word delivered");
		u_host.scan(1'h0, DAT_W, $urandom, d);
		chk(d[BUSY_BIT], 1'h0, "busy after drain");
		// dropping test reset hands the pins back to functional mode
		@(negedge mclk);
		trst = 1'h0;
		b_drv = 1'h0;
		settle();
		chk({sc, a_oe_n, b_oe_n, xoe_n, ev_b, tdo_oe_n}, 6'h19, "functional mode");
		tally_and_finish();
	end
endmodule
